/* File: dv/tb.sv */
`timescale 1ns/100ps
module tb;
  import tw_pkg::*;
  // ****
  // Design, slave and RAM
  // ****
  localparam logic [6:0] SADDR = 7'h2A;
  logic            clk_sys = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, nack = 0;
  logic            mem_rd, mem_wr, scl_o, sda_o, scl_oe, sda_oe, s_scl, s_sda;
  logic [7:0]      reg_addr = 0, mem_rdata = 0, mem_wdata, ram [0:255], exp_q[$];
  logic [15:0]     mem_addr;
  logic [31:0]     reg_wdata = 0, reg_rdata, v;
  logic [EV_W-1:0] events;
  wire             scl_i = ~scl_oe & ~s_scl;
  wire             sda_i = ~sda_oe & ~s_sda;
  int              errors = 0, n_tests = 0, cyc = 0, lo_c = 0, lo_min, stretch = 0;
  int              hc[3] = '{HALF_SLOW_CYC, HALF_MID_CYC, HALF_FAST_CYC};
  tw_master i_tw_master (.*);
  tw_slave_model #(.SADDR(SADDR)) i_tw_slave_model (.scl(scl_i), .sda(sda_i), .nack(nack),
    .stretch_ns(stretch), .scl_pull(s_scl), .sda_pull(s_sda));
  initial forever #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    mem_rdata <= ram[mem_addr[7:0]];
    if (mem_wr) ram[mem_addr[7:0]] <= mem_wdata;
    lo_c <= scl_oe ? lo_c + 1 : 0;
    if (!scl_oe && lo_c > 0 && lo_c < lo_min) lo_min <= lo_c;
    if (cyc == 90000) begin
      errors++;
      complete_run();
    end
  end
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(logic [7:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  task automatic wev(int b);
    while (events[b] !== 1'b1) @(posedge clk_sys);
  endtask : wev
  task automatic go(int r, int rx, int len, logic sc);
    lo_min = 999;
    i_tw_slave_model.rx_q = {};
    wr(OFF_EVENTS, 32'h7F);
    wr(OFF_CONFIG, {15'h0, sc, 1'b0, SADDR, 6'h0, 2'(r)});
    wr(rx ? OFF_RX_LEN : OFF_TX_LEN, len);
    wr(OFF_TASKS, 1 << rx);
  endtask : go
  task automatic complete_run();
    if (errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  initial begin
    v = $urandom(49);
    foreach (ram[k]) ram[k] = 8'($urandom);
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(8'hFC);
    chk("unmapped", v, 0);
    foreach (hc[r]) begin
      stretch = r * 3000;
      go(r, 0, 2, 1'b1);
      wev(EV_STOPPED);
      exp_q = {ram[0], ram[1]};
      chk("low phase", lo_min, hc[r]);
      chk("tx bytes", i_tw_slave_model.rx_q == exp_q, 1);
      chk("tx events", events, 7'h29);
    end
    nack = 1'b1;
    go(0, 0, 1, 1'b0);
    repeat (3000) @(posedge clk_sys);
    rd(OFF_STATUS);
    chk("nack", {v[1:0], events[EV_STOPPED], events[EV_ERROR]}, 4'b0101);
    nack = 1'b0;
    wr(OFF_TASKS, 1 << TASK_STOP);
    wev(EV_STOPPED);
    exp_q = {8'($urandom), 8'($urandom), 8'($urandom)};
    i_tw_slave_model.tx_q = exp_q;
    wr(OFF_RX_PTR, 32'h40);
    go(1, 1, 3, 1'b1);
    wev(EV_STOPPED);
    chk("rx bytes", {ram[64], ram[65], ram[66]}, {exp_q[0], exp_q[1], exp_q[2]});
    chk("rx events", events, 7'h51);
    go(2, 0, 3, 1'b0);
    wev(EV_TX_BEGAN);
    wr(OFF_TASKS, 1 << TASK_SUSPEND);
    wev(EV_SUSPENDED);
    wr(OFF_TASKS, 1 << TASK_STOP);
    repeat (200) @(posedge clk_sys);
    chk("suspend", {scl_i, events[EV_STOPPED], 8'(i_tw_slave_model.bit_n)}, 0);
    wr(OFF_TASKS, 1 << TASK_RESUME);
    wr(OFF_TASKS, 1 << TASK_STOP);
    wev(EV_STOPPED);
    wr(OFF_EVENTS, 32'h7F);
    wr(OFF_TASKS, 1 << TASK_SUSPEND);
    repeat (20) @(posedge clk_sys);
    chk("idle suspend", events, 0);
    complete_run();
  end
endmodule : tb

/* File: dv/tw_master_monitor.sv */
`timescale 1ns/100ps
module tw_master_monitor
  import tw_pkg::*;
(
  // Control
  input wire logic            clk_sys,
  input wire logic            sys_rst,
  input wire logic            reg_wr,
  // Pins, RAM and events
  input wire logic            scl_i,
  input wire logic            scl_o,
  input wire logic            scl_oe,
  input wire logic            sda_i,
  input wire logic            sda_o,
  input wire logic            sda_oe,
  input wire logic            mem_rd,
  input wire logic            mem_wr,
  input wire logic [EV_W-1:0] events
);
  // ****
  // Pin and event checks
  // ****
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  pins_low_a: assert property (!scl_o && !sda_o) else $error("pin high");
  stretch_wait_a: assert property (!scl_oe && !scl_i |=> !scl_oe)
    else $error("stretch ignored");
  start_hold_a: assert property ($rose(sda_oe) && !scl_oe |-> !scl_oe [*8])
    else $error("start too short");
  low_phase_a: assert property ($rose(scl_oe) |-> scl_oe [*8])
    else $error("low phase short");
  susp_hold_a: assert property ($rose(events[EV_SUSPENDED]) |-> scl_oe [*8])
    else $error("clock not held");
  stop_bus_a: assert property ($rose(events[EV_STOPPED]) |-> scl_i && sda_i && !sda_oe)
    else $error("stop not on bus");
  stop_ram_a: assert property ($rose(events[EV_STOPPED]) |-> !mem_wr && !$past(mem_rd))
    else $error("ram busy at stop");
  stop_keep_a: assert property ($past(events[EV_STOPPED]) && !$past(reg_wr) |->
    events[EV_STOPPED]) else $error("stopped lost");
endmodule : tw_master_monitor
bind tw_master tw_master_monitor i_mon (.*);

/* File: dv/tw_slave_model.sv */
`timescale 1ns/100ps
module tw_slave_model #(
  parameter logic [6:0] SADDR = 7'h2A
) (
  // Lines after pull-ups
  input  wire logic scl,
  input  wire logic sda,
  // Scenario control
  input  wire logic nack,
  input  wire integer stretch_ns,
  // Pulls, high while pulling low
  output logic      scl_pull = 0,
  output logic      sda_pull = 0
);
  // ****
  // Behavioural slave
  // ****
  logic [7:0] rx_q[$], tx_q[$], sh, tb_b;
  logic       act = 0, rd_mode = 0, first = 0;
  int         bit_n = 0;
  always @(negedge sda) if (scl) begin
    act = 1;
    first = 1;
    bit_n = -1;
  end
  always @(posedge sda) if (scl) act = 0;
  always @(posedge scl) begin
    if (act && bit_n < 8) sh = {sh[6:0], sda};
    // A refused final byte ends the read, so the stop can pass
    if (act && bit_n == 8 && rd_mode && !first && sda) act = 0;
  end
  always @(negedge scl) if (act) begin
    sda_pull = 1'b0;
    bit_n++;
    if (bit_n == 8 && first) rd_mode = sh[0];
    if (bit_n == 8 && first) act = (sh[7:1] == SADDR);
    if (bit_n == 8 && !first && !rd_mode) rx_q.push_back(sh);
    if (bit_n == 8 && act) sda_pull = (first || !rd_mode) && !nack;
    if (bit_n == 9) begin
      bit_n = 0;
      first = 0;
      if (rd_mode) tb_b = tx_q.pop_front();
    end
    if (rd_mode && !first && bit_n < 8) sda_pull = !tb_b[7 - bit_n];
    scl_pull = 1'b1;
    #(stretch_ns) scl_pull = 1'b0;
  end
endmodule : tw_slave_model

/* File: rtl/tw_half_div.sv */
`timescale 1ns/100ps
module tw_half_div
  import tw_pkg::*;
#(
  parameter int CNT_W = DIV_W
) (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  // Control
  input  wire logic [1:0] rate_sel,
  input  wire logic       restart,
  // Half bit enable
  output logic            tick
);

  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic [CNT_W-1:0] limit;
  logic             nxt_tick;

  // Tick and the caller's flag each add a cycle, so the count stops short
  always_comb begin
    unique case (rate_sel)
      RATE_SEL_MID:  limit = CNT_W'(HALF_MID_CYC - 3);
      RATE_SEL_FAST: limit = CNT_W'(HALF_FAST_CYC - 3);
      default:       limit = CNT_W'(HALF_SLOW_CYC - 3);
    endcase
    nxt_cnt  = cnt_ff + CNT_W'(1);
    nxt_tick = 1'b0;
    if (restart) begin
      nxt_cnt = '0;
    end else if (cnt_ff >= limit) begin
      nxt_cnt  = '0;
      nxt_tick = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cnt_ff <= '0;
      tick   <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tick   <= nxt_tick;
    end
  end

endmodule : tw_half_div

/* File: rtl/tw_master.sv */
// Overview of operation
// R01 - Bit rate 100, 250 or 400 kbps selectable
// R02 - Wait while slave holds clock low
// R03 - Pulse after stretch may be short
// R04 - Sole bus master, no arbitration
// R05 - Seven-bit slave address
// R06 - Begin tasks start, stop task ends
// R07 - Stopped event once fully stopped
// R08 - Host waits for final/stopped before restarting
// R09 - Suspend: event, clock held low until resume
// R10 - Stop ignored while suspended
// R11 - Current byte completes before suspending
// R12 - Suspend ignored when not transferring
// R13 - Not-acknowledge from slave raises error
// R14 - Bytes move to and from RAM directly
// R15 - Pointer and length double-buffered
// R16 - Stopped only after RAM access done
// R17 - Plain two-wire signalling, no CBUS
// R18 - Start, address, direction bit, acknowledge
// R19 - Acknowledge all read bytes but last
// R20 - Final-transmit event at last byte start
// R21 - No automatic stop on exhaustion or error; stops at buffer end when cfg_short_ff is set
// R22 - Stop condition after byte, then event
`timescale 1ns/100ps
module tw_master
  import tw_pkg::*;
#(
  parameter int AW    = 16,
  parameter int LEN_W = 16
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  // Register port
  input  wire logic [7:0]       reg_addr,
  input  wire logic [31:0]      reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [31:0]      reg_rdata,
  // RAM port
  output logic      [AW-1:0]    mem_addr,
  output logic                  mem_rd,
  input  wire logic [7:0]       mem_rdata,
  output logic                  mem_wr,
  output logic      [7:0]       mem_wdata,
  // Two-wire pins, open drain
  input  wire logic             scl_i,
  output logic                  scl_o,
  output logic                  scl_oe,
  input  wire logic             sda_i,
  output logic                  sda_o,
  output logic                  sda_oe,
  // Event flags
  output logic      [EV_W-1:0]  events
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  tw_state_t        state_ff, nxt_state;
  logic             half_ok_ff, nxt_half_ok, tick, restart;
  logic [1:0]       pins_s;
  logic             scl_s, sda_s;
  logic             nxt_scl_oe, nxt_sda_oe;
  logic [7:0]       shreg_ff, nxt_shreg;
  logic [3:0]       bit_cnt_ff, nxt_bit_cnt;
  logic             is_addr_ff, nxt_is_addr, is_read_ff, nxt_is_read;
  logic [LEN_W-1:0] tx_cnt_ff, nxt_tx_cnt, rx_cnt_ff, nxt_rx_cnt;
  logic [AW-1:0]    tx_ptr_act_ff, nxt_tx_ptr_act, rx_ptr_act_ff, nxt_rx_ptr_act;
  logic [LEN_W-1:0] tx_len_act_ff, nxt_tx_len_act, rx_len_act_ff, nxt_rx_len_act;
  logic [7:0]       tx_byte_ff, nxt_tx_byte;
  logic             have_byte_ff, nxt_have_byte, rd_busy_ff;
  logic             nxt_mem_rd, nxt_mem_wr;
  logic [AW-1:0]    nxt_mem_addr;
  logic [7:0]       nxt_mem_wdata;
  logic             pend_tx_ff, nxt_pend_tx, pend_rx_ff, nxt_pend_rx;
  logic             pend_stop_ff, nxt_pend_stop, pend_susp_ff, nxt_pend_susp;
  logic [EV_W-1:0]  ev_set, nxt_events;
  logic             do_load, active, dma_idle, rx_last;
  // Register file
  logic [1:0]       cfg_rate_ff, nxt_cfg_rate;
  logic [6:0]       cfg_saddr_ff, nxt_cfg_saddr;
  logic             cfg_short_ff, nxt_cfg_short;
  logic [AW-1:0]    tx_ptr_ff, nxt_tx_ptr, rx_ptr_ff, nxt_rx_ptr;
  logic [LEN_W-1:0] tx_len_ff, nxt_tx_len, rx_len_ff, nxt_rx_len;
  logic [31:0]      nxt_rdata;
  logic             task_wr;
  logic [4:0]       task_bits;

  // Only the enables move; a released line floats high on its pull-up
  assign scl_o = 1'b0;  // [R17]
  assign sda_o = 1'b0;

  // ****************************************************************
  // Pin sampling and bit timing
  // ****************************************************************
  tw_sync #(.W(2)) u_sync (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .async_in ({scl_i, sda_i}),
    .sync_out (pins_s)
  );
  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  assign restart = (nxt_state != state_ff);

  tw_half_div u_div (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .rate_sel (cfg_rate_ff),   // [R01]
    .restart  (restart),
    .tick     (tick)
  );

  // ****************************************************************
  // Bus engine
  // ****************************************************************
  assign task_wr   = reg_wr && (reg_addr == OFF_TASKS);
  assign task_bits = task_wr ? reg_wdata[4:0] : 5'h00;
  assign active    = (state_ff != ST_IDLE) && (state_ff != ST_SP_LOW) &&
                     (state_ff != ST_SP_SCL) && (state_ff != ST_SP_REL);
  assign dma_idle  = !mem_rd && !rd_busy_ff && !mem_wr;
  assign rx_last   = (LEN_W'(rx_cnt_ff + LEN_W'(1)) >= rx_len_act_ff);

  always_comb begin
    nxt_state      = state_ff;
    nxt_half_ok    = half_ok_ff | tick;
    nxt_scl_oe     = scl_oe;
    nxt_sda_oe     = sda_oe;
    nxt_shreg      = shreg_ff;
    nxt_bit_cnt    = bit_cnt_ff;
    nxt_is_addr    = is_addr_ff;
    nxt_is_read    = is_read_ff;
    nxt_tx_cnt     = tx_cnt_ff;
    nxt_rx_cnt     = rx_cnt_ff;
    nxt_tx_ptr_act = tx_ptr_act_ff;
    nxt_rx_ptr_act = rx_ptr_act_ff;
    nxt_tx_len_act = tx_len_act_ff;
    nxt_rx_len_act = rx_len_act_ff;
    nxt_tx_byte    = tx_byte_ff;
    nxt_have_byte  = have_byte_ff;
    nxt_mem_rd     = 1'b0;
    nxt_mem_wr     = 1'b0;
    nxt_mem_addr   = mem_addr;
    nxt_mem_wdata  = mem_wdata;
    nxt_pend_tx    = pend_tx_ff | task_bits[TASK_BEGIN_TX];             // [R06]
    nxt_pend_rx    = pend_rx_ff | task_bits[TASK_BEGIN_RX];             // [R06]
    // A stop while suspended is dropped, not deferred
    nxt_pend_stop  = pend_stop_ff |
                     (task_bits[TASK_STOP] && state_ff != ST_SUSP &&
                      state_ff != ST_IDLE);                            // [R10]
    nxt_pend_susp  = pend_susp_ff | (task_bits[TASK_SUSPEND] && active); // [R12]
    ev_set         = '0;
    do_load        = 1'b0;
    if (rd_busy_ff) begin
      nxt_tx_byte   = mem_rdata;                                       // [R14]
      nxt_have_byte = 1'b1;
    end
    unique case (state_ff)
      ST_IDLE: begin
        nxt_scl_oe = 1'b0;
        nxt_sda_oe = 1'b0;
        if (task_bits[TASK_STOP]) begin
          ev_set[EV_STOPPED] = 1'b1;
        end
        if (pend_tx_ff || pend_rx_ff) begin
          nxt_sda_oe = 1'b1;                                           // [R18]
          do_load    = 1'b1;
          nxt_state  = ST_START;
        end
      end
      ST_RS_REL: begin
        nxt_sda_oe = 1'b0;
        if (half_ok_ff) begin
          nxt_scl_oe = 1'b0;
          nxt_state  = ST_RS_SCL;
        end
      end
      ST_RS_SCL: begin
        if (half_ok_ff && scl_s) begin                                 // [R02]
          nxt_sda_oe = 1'b1;
          do_load    = 1'b1;
          nxt_state  = ST_START;
        end
      end
      ST_START: begin
        if (half_ok_ff) begin
          nxt_scl_oe = 1'b1;
          nxt_state  = ST_BIT_LO;
        end
      end
      ST_BIT_LO: begin
        // Data changes a cycle after the clock fell, giving hold time
        if (bit_cnt_ff == ACK_SLOT) begin
          nxt_sda_oe = (is_read_ff && !is_addr_ff) ? !rx_last : 1'b0;  // [R19]
        end else begin
          nxt_sda_oe = (is_read_ff && !is_addr_ff) ? 1'b0 : !shreg_ff[7];  // [R04]
        end
        if (half_ok_ff) begin
          nxt_scl_oe = 1'b0;
          nxt_state  = ST_BIT_HI;
        end
      end
      ST_BIT_HI: begin
        // High time runs from release, so a stretched pulse ends early
        if (half_ok_ff && scl_s) begin                                 // [R02] [R03]
          nxt_scl_oe = 1'b1;
          if (bit_cnt_ff != ACK_SLOT) begin
            nxt_shreg   = {shreg_ff[6:0], sda_s};
            nxt_bit_cnt = bit_cnt_ff + 4'h1;
            nxt_state   = ST_BIT_LO;
          end else begin
            nxt_state = ST_WAIT;
            if ((is_addr_ff || !is_read_ff) && sda_s) begin
              ev_set[EV_ERROR] = 1'b1;                                 // [R13] [R21]
            end
            if (is_addr_ff) begin
              nxt_is_addr = 1'b0;
              if (is_read_ff && rx_len_act_ff == LEN_W'(1)) begin
                ev_set[EV_FINAL_RX] = 1'b1;
              end
            end else if (!is_read_ff) begin
              nxt_tx_cnt = LEN_W'(tx_cnt_ff + LEN_W'(1));
            end else begin
              nxt_mem_wr    = 1'b1;                                    // [R14]
              nxt_mem_addr  = rx_ptr_act_ff + AW'(rx_cnt_ff);
              nxt_mem_wdata = shreg_ff;
              nxt_rx_cnt    = LEN_W'(rx_cnt_ff + LEN_W'(1));
              if (rx_len_act_ff > LEN_W'(1) &&
                  LEN_W'(rx_cnt_ff + LEN_W'(2)) == rx_len_act_ff) begin
                ev_set[EV_FINAL_RX] = 1'b1;
              end
            end
          end
        end
      end
      ST_WAIT: begin
        // Clock stays low at a byte boundary; buffer end stops it only when cfg_short_ff is set
        nxt_sda_oe = 1'b0;                                             // [R21]
        // A read runs on to its refused final byte before it may stop
        if (pend_stop_ff && !(is_read_ff && rx_cnt_ff < rx_len_act_ff)) begin // [R19]
          nxt_pend_stop = 1'b0;
          nxt_state     = ST_SP_LOW;                                   // [R22]
        end else if (pend_tx_ff || pend_rx_ff) begin
          nxt_state = ST_RS_REL;
        end else if (pend_susp_ff) begin
          nxt_pend_susp          = 1'b0;
          ev_set[EV_SUSPENDED]   = 1'b1;                               // [R09] [R11]
          nxt_state              = ST_SUSP;
        end else if (!is_read_ff && tx_cnt_ff < tx_len_act_ff) begin
          if (have_byte_ff) begin
            nxt_shreg     = tx_byte_ff;
            nxt_have_byte = 1'b0;
            nxt_bit_cnt   = 4'h0;
            nxt_state     = ST_BIT_LO;
            if (tx_cnt_ff == LEN_W'(tx_len_act_ff - LEN_W'(1))) begin
              ev_set[EV_FINAL_TX] = 1'b1;                              // [R20]
            end
          end else if (!mem_rd && !rd_busy_ff) begin
            nxt_mem_rd   = 1'b1;                                       // [R14]
            nxt_mem_addr = tx_ptr_act_ff + AW'(tx_cnt_ff);
          end
        end else if (is_read_ff && rx_cnt_ff < rx_len_act_ff) begin
          nxt_bit_cnt = 4'h0;
          nxt_state   = ST_BIT_LO;
        end
      end
      ST_SUSP: begin
        nxt_scl_oe = 1'b1;                                             // [R09]
        if (task_bits[TASK_RESUME]) begin
          nxt_state = ST_WAIT;
        end
      end
      ST_SP_LOW: begin
        nxt_sda_oe = 1'b1;
        if (half_ok_ff) begin
          nxt_scl_oe = 1'b0;
          nxt_state  = ST_SP_SCL;
        end
      end
      ST_SP_SCL: begin
        if (half_ok_ff && scl_s) begin                                 // [R02]
          nxt_sda_oe = 1'b0;                                           // [R22]
          nxt_state  = ST_SP_REL;
        end
      end
      ST_SP_REL: begin
        if (half_ok_ff && dma_idle) begin
          ev_set[EV_STOPPED] = 1'b1;                                   // [R07] [R16]
          // Stop and suspend requests caught while stopping must not leak into the next run
          nxt_pend_stop      = 1'b0;
          nxt_pend_susp      = 1'b0;
          nxt_state          = ST_IDLE;
        end
      end
    endcase
    if (do_load) begin
      // Shadow values are copied here, so software may refill them now
      nxt_is_read    = !pend_tx_ff;
      nxt_pend_tx    = 1'b0;
      nxt_pend_rx    = 1'b0;
      nxt_is_addr    = 1'b1;
      nxt_shreg      = {cfg_saddr_ff, pend_tx_ff ? DIR_WRITE : DIR_READ}; // [R05] [R18]
      nxt_bit_cnt    = 4'h0;
      nxt_tx_cnt     = '0;
      nxt_rx_cnt     = '0;
      nxt_have_byte  = 1'b0;
      nxt_tx_ptr_act = tx_ptr_ff;                                      // [R15]
      nxt_tx_len_act = tx_len_ff;
      nxt_rx_ptr_act = rx_ptr_ff;
      nxt_rx_len_act = rx_len_ff;
      ev_set[pend_tx_ff ? EV_TX_BEGAN : EV_RX_BEGAN] = 1'b1;
    end
    if (cfg_short_ff && (ev_set[EV_FINAL_TX] || ev_set[EV_FINAL_RX])) begin
      nxt_pend_stop = 1'b1;
    end
    // Each state starts its half period afresh
    if (nxt_state != state_ff) begin
      nxt_half_ok = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_ff      <= ST_IDLE;
      half_ok_ff    <= 1'b0;
      scl_oe        <= 1'b0;
      sda_oe        <= 1'b0;
      shreg_ff      <= 8'h00;
      bit_cnt_ff    <= 4'h0;
      is_addr_ff    <= 1'b0;
      is_read_ff    <= 1'b0;
      tx_cnt_ff     <= '0;
      rx_cnt_ff     <= '0;
      tx_ptr_act_ff <= '0;
      rx_ptr_act_ff <= '0;
      tx_len_act_ff <= '0;
      rx_len_act_ff <= '0;
      tx_byte_ff    <= 8'h00;
      have_byte_ff  <= 1'b0;
      rd_busy_ff    <= 1'b0;
      mem_rd        <= 1'b0;
      mem_wr        <= 1'b0;
      mem_addr      <= '0;
      mem_wdata     <= 8'h00;
      pend_tx_ff    <= 1'b0;
      pend_rx_ff    <= 1'b0;
      pend_stop_ff  <= 1'b0;
      pend_susp_ff  <= 1'b0;
    end else begin
      state_ff      <= nxt_state;
      half_ok_ff    <= nxt_half_ok;
      scl_oe        <= nxt_scl_oe;
      sda_oe        <= nxt_sda_oe;
      shreg_ff      <= nxt_shreg;
      bit_cnt_ff    <= nxt_bit_cnt;
      is_addr_ff    <= nxt_is_addr;
      is_read_ff    <= nxt_is_read;
      tx_cnt_ff     <= nxt_tx_cnt;
      rx_cnt_ff     <= nxt_rx_cnt;
      tx_ptr_act_ff <= nxt_tx_ptr_act;
      rx_ptr_act_ff <= nxt_rx_ptr_act;
      tx_len_act_ff <= nxt_tx_len_act;
      rx_len_act_ff <= nxt_rx_len_act;
      tx_byte_ff    <= nxt_tx_byte;
      have_byte_ff  <= nxt_have_byte;
      rd_busy_ff    <= mem_rd;
      mem_rd        <= nxt_mem_rd;
      mem_wr        <= nxt_mem_wr;
      mem_addr      <= nxt_mem_addr;
      mem_wdata     <= nxt_mem_wdata;
      pend_tx_ff    <= nxt_pend_tx;
      pend_rx_ff    <= nxt_pend_rx;
      pend_stop_ff  <= nxt_pend_stop;
      pend_susp_ff  <= nxt_pend_susp;
    end
  end

  // ****************************************************************
  // Register file
  // ****************************************************************
  always_comb begin
    nxt_cfg_rate  = cfg_rate_ff;
    nxt_cfg_saddr = cfg_saddr_ff;
    nxt_cfg_short = cfg_short_ff;
    nxt_tx_ptr    = tx_ptr_ff;
    nxt_tx_len    = tx_len_ff;
    nxt_rx_ptr    = rx_ptr_ff;
    nxt_rx_len    = rx_len_ff;
    nxt_events    = events;
    nxt_rdata     = 32'h0000_0000;
    if (reg_wr) begin
      unique case (reg_addr)
        OFF_EVENTS: nxt_events = events & ~reg_wdata[EV_W-1:0];
        OFF_CONFIG: begin
          nxt_cfg_rate  = reg_wdata[CFG_RATE_LSB +: 2];                // [R01]
          nxt_cfg_saddr = reg_wdata[CFG_ADDR_LSB +: 7];
          nxt_cfg_short = reg_wdata[CFG_SHORT_BIT];
        end
        OFF_TX_PTR: nxt_tx_ptr = reg_wdata[AW-1:0];
        OFF_TX_LEN: nxt_tx_len = reg_wdata[LEN_W-1:0];
        OFF_RX_PTR: nxt_rx_ptr = reg_wdata[AW-1:0];
        OFF_RX_LEN: nxt_rx_len = reg_wdata[LEN_W-1:0];
        default: ;
      endcase
    end
    // Hardware set wins over a clear in the same cycle
    nxt_events = nxt_events | ev_set;
    if (reg_rd) begin
      unique case (reg_addr)
        OFF_EVENTS:    nxt_rdata = 32'(events);
        OFF_CONFIG:    nxt_rdata = (32'(cfg_short_ff) << CFG_SHORT_BIT) |
                                   (32'(cfg_saddr_ff) << CFG_ADDR_LSB) |
                                   32'(cfg_rate_ff);
        OFF_TX_PTR:    nxt_rdata = 32'(tx_ptr_ff);
        OFF_TX_LEN:    nxt_rdata = 32'(tx_len_ff);
        OFF_RX_PTR:    nxt_rdata = 32'(rx_ptr_ff);
        OFF_RX_LEN:    nxt_rdata = 32'(rx_len_ff);
        OFF_TX_AMOUNT: nxt_rdata = 32'(tx_cnt_ff);
        OFF_RX_AMOUNT: nxt_rdata = 32'(rx_cnt_ff);
        OFF_STATUS:    nxt_rdata = {30'h0000_0000, state_ff == ST_SUSP,
                                    state_ff != ST_IDLE};
        default:       nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cfg_rate_ff  <= RST_RATE;
      cfg_saddr_ff <= RST_SADDR;
      cfg_short_ff <= 1'b0;
      tx_ptr_ff    <= AW'(RST_WORD);
      tx_len_ff    <= LEN_W'(RST_WORD);
      rx_ptr_ff    <= AW'(RST_WORD);
      rx_len_ff    <= LEN_W'(RST_WORD);
      events       <= '0;
      reg_rdata    <= 32'h0000_0000;
    end else begin
      cfg_rate_ff  <= nxt_cfg_rate;
      cfg_saddr_ff <= nxt_cfg_saddr;
      cfg_short_ff <= nxt_cfg_short;
      tx_ptr_ff    <= nxt_tx_ptr;
      tx_len_ff    <= nxt_tx_len;
      rx_ptr_ff    <= nxt_rx_ptr;
      rx_len_ff    <= nxt_rx_len;
      events       <= nxt_events;
      reg_rdata    <= nxt_rdata;
    end
  end

endmodule : tw_master

/* File: rtl/tw_pkg.sv */
package tw_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS  = 100;
  localparam int NS_KBPS_BIT    = 1000000;
  localparam int RATE_SLOW_KBPS = 100;
  localparam int RATE_MID_KBPS  = 250;
  localparam int RATE_FAST_KBPS = 400;
  // Half bit periods are least times, so they round up
  localparam int HALF_SLOW_CYC  =
    (NS_KBPS_BIT / (2 * RATE_SLOW_KBPS) + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HALF_MID_CYC   =
    (NS_KBPS_BIT / (2 * RATE_MID_KBPS) + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HALF_FAST_CYC  =
    (NS_KBPS_BIT / (2 * RATE_FAST_KBPS) + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DIV_W          = 8;

  localparam logic [1:0] RATE_SEL_SLOW = 2'h0;
  localparam logic [1:0] RATE_SEL_MID  = 2'h1;
  localparam logic [1:0] RATE_SEL_FAST = 2'h2;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] OFF_TASKS     = 8'h00;
  localparam logic [7:0] OFF_EVENTS    = 8'h04;
  localparam logic [7:0] OFF_CONFIG    = 8'h08;
  localparam logic [7:0] OFF_TX_PTR    = 8'h0C;
  localparam logic [7:0] OFF_TX_LEN    = 8'h10;
  localparam logic [7:0] OFF_RX_PTR    = 8'h14;
  localparam logic [7:0] OFF_RX_LEN    = 8'h18;
  localparam logic [7:0] OFF_TX_AMOUNT = 8'h1C;
  localparam logic [7:0] OFF_RX_AMOUNT = 8'h20;
  localparam logic [7:0] OFF_STATUS    = 8'h24;

  localparam int TASK_BEGIN_TX = 0;
  localparam int TASK_BEGIN_RX = 1;
  localparam int TASK_STOP     = 2;
  localparam int TASK_SUSPEND  = 3;
  localparam int TASK_RESUME   = 4;

  localparam int EV_W          = 7;
  localparam int EV_STOPPED    = 0;
  localparam int EV_ERROR      = 1;
  localparam int EV_SUSPENDED  = 2;
  localparam int EV_FINAL_TX   = 3;
  localparam int EV_FINAL_RX   = 4;
  localparam int EV_TX_BEGAN   = 5;
  localparam int EV_RX_BEGAN   = 6;

  localparam int CFG_RATE_LSB  = 0;
  localparam int CFG_ADDR_LSB  = 8;
  localparam int CFG_SHORT_BIT = 16;

  localparam logic [1:0]  RST_RATE  = 2'h0;
  localparam logic [6:0]  RST_SADDR = 7'h00;
  localparam logic [15:0] RST_WORD  = 16'h0000;

  // ****************************************************************
  // Bus encodings
  // ****************************************************************
  localparam logic       DIR_WRITE = 1'b0;
  localparam logic       DIR_READ  = 1'b1;
  localparam logic [3:0] ACK_SLOT  = 4'h8;

  typedef enum logic [10:0] {
    ST_IDLE   = 11'h001,
    ST_START  = 11'h002,
    ST_RS_REL = 11'h004,
    ST_RS_SCL = 11'h008,
    ST_BIT_LO = 11'h010,
    ST_BIT_HI = 11'h020,
    ST_WAIT   = 11'h040,
    ST_SUSP   = 11'h080,
    ST_SP_LOW = 11'h100,
    ST_SP_SCL = 11'h200,
    ST_SP_REL = 11'h400
  } tw_state_t;

endpackage : tw_pkg

/* File: rtl/tw_sync.sv */
`timescale 1ns/100ps
module tw_sync #(
  parameter int W = 2
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         sys_rst,
  // Data
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_ff;

  // Idle bus level is high, so reset to one
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
        meta_ff[i]  <= 1'b1;
        sync_out[i] <= 1'b1;
      end else begin
        meta_ff[i]  <= async_in[i];
        sync_out[i] <= meta_ff[i];
      end
    end
  end

endmodule : tw_sync
